// File: cbtcp_top.v
// Purpose: bit timing, channel page and channel control sfrs of a can controller
// Assumes: cpu sfr port with one-cycle write strobe and read strobe
// Notes:   bit timer ticks on the prescaled can system clock
`timescale 1ns/1ps
`include "cbtcp_consts.vh"
module cbtcp_top (
    // clock and reset
    input  wire        clk_sys,
    input  wire        rst_n,
    // sfr port
    input  wire [7:0]  sfr_addr,
    input  wire [7:0]  sfr_wdata,
    input  wire        sfr_wr,
    input  wire        sfr_rd,
    output reg  [7:0]  sfr_rdata,
    // data register access strobe from the message data path
    input  wire        data_access,
    // global control
    input  wire        controller_enable,
    // can bus
    input  wire        can_rx,
    output reg         bit_value,
    output reg         sample_strobe,
    input  wire        resync_edge_early,
    input  wire        resync_edge_late,
    // channel status
    output reg  [14:0] channel_enabled,
    output reg  [3:0]  channel_select,
    output reg  [2:0]  byte_index
);
    reg        rst_meta;
    reg        rst_sync_n;
    reg        rx_meta;
    reg        rx_sync;
    reg        index_autoinc_n;
    reg [7:0]  bt1;
    reg [7:0]  bt2;
    reg [7:0]  bt3;
    reg        timing_valid;
    reg [5:0]  presc_cnt;
    reg [4:0]  tq_cnt;
    reg [1:0]  seg;
    reg [2:0]  rx_hist;
    reg        rd_chctrl;
    wire [7:0] chctrl_rdata;
    wire       wr_hit_page   = sfr_wr && sfr_addr == `CBTCP_ADDR_PAGE;
    wire       wr_hit_chctrl = sfr_wr && sfr_addr == `CBTCP_ADDR_CHCTRL;
    wire       bt_unlocked  = ~controller_enable;

    localparam SEG_SYNC = 2'h0;
    localparam SEG_PROP = 2'h1;
    localparam SEG_PH1  = 2'h2;
    localparam SEG_PH2  = 2'h3;

    wire [5:0] presc_field = bt1[`CBTCP_BT1_PRESC];
    wire [1:0] jump_field  = bt2[`CBTCP_BT2_JUMP];
    wire [2:0] prop_field  = bt2[`CBTCP_BT2_PROP];
    wire [2:0] ph1_field   = bt3[`CBTCP_BT3_PH1];
    wire [2:0] ph2_field   = bt3[`CBTCP_BT3_PH2];
    wire       triple_sample_sel = bt3[`CBTCP_BT3_TRIPLE];

    function [4:0] seg_len;
        input [2:0] f;
        seg_len = {2'h0, f} + 5'h01;
    endfunction

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    always @(posedge clk_sys) begin
        rx_meta <= can_rx;
        rx_sync <= rx_meta;
    end

    // channel control bytes live per channel
    cbtcp_chan_mem u_mem (
        .clk_sys (clk_sys),
        .wr_en   (wr_hit_chctrl),
        .wr_addr (channel_select),
        .wr_data (sfr_wdata),
        .rd_addr (channel_select),
        .rd_data (chctrl_rdata)
    );

    // page, timing-valid flag and channel enable registers
    always @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            {channel_select, index_autoinc_n, byte_index} <= `CBTCP_PAGE_RESET;
            timing_valid    <= 1'b0;
            channel_enabled <= 15'h0000;
        end else begin
            if (wr_hit_page) begin
                channel_select  <= sfr_wdata[`CBTCP_PAGE_CHAN];
                index_autoinc_n <= sfr_wdata[`CBTCP_PAGE_STEP_N];
                byte_index      <= sfr_wdata[`CBTCP_PAGE_INDEX];
            end else if (data_access && !index_autoinc_n) begin
                byte_index <= byte_index + 3'h1;
            end
            if (sfr_wr && sfr_addr == `CBTCP_ADDR_BT3 && bt_unlocked) begin
                timing_valid <= 1'b1;
            end
            if (wr_hit_chctrl && channel_select <= `CBTCP_CHAN_LAST) begin
                channel_enabled[channel_select] <=
                    sfr_wdata[`CBTCP_CHCTRL_CFG] != `CBTCP_CFG_DISABLED;
            end
        end
    end

    // timing bytes: no reset value; bit 7 forced low so it is never set
    always @(posedge clk_sys) begin
        if (sfr_wr && bt_unlocked) begin
            if (sfr_addr == `CBTCP_ADDR_BT1) begin
                bt1 <= {1'b0, sfr_wdata[6:1], 1'b0};
            end
            if (sfr_addr == `CBTCP_ADDR_BT2) begin
                bt2 <= {1'b0, sfr_wdata[6:5], 1'b0, sfr_wdata[3:1], 1'b0};
            end
            if (sfr_addr == `CBTCP_ADDR_BT3) begin
                bt3 <= {1'b0, sfr_wdata[6:0]};
            end
        end
    end

    // read mux, registered; control byte arrives one cycle later from memory
    always @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sfr_rdata <= 8'h00;
            rd_chctrl <= 1'b0;
        end else begin
            rd_chctrl <= sfr_rd && sfr_addr == `CBTCP_ADDR_CHCTRL;
            if (rd_chctrl) begin
                sfr_rdata <= chctrl_rdata;
            end else if (sfr_rd) begin
                case (sfr_addr)
                    `CBTCP_ADDR_PAGE: sfr_rdata <= {channel_select, index_autoinc_n, byte_index};
                    `CBTCP_ADDR_BT1:  sfr_rdata <= bt1;
                    `CBTCP_ADDR_BT2:  sfr_rdata <= bt2;
                    `CBTCP_ADDR_BT3:  sfr_rdata <= bt3;
                    default:          sfr_rdata <= 8'h00;
                endcase
            end
        end
    end

    // bit timer: prescaler makes the time quantum
    wire tq_tick = presc_cnt == presc_field;
    wire [4:0] jump_len = seg_len({1'b0, jump_field});
    // late edge stretches phase one by the jump width
    wire [4:0] ph1_len = seg_len(ph1_field) + (resync_edge_late ? jump_len : 5'h00);
    // early edge shortens phase two, floored at one quantum so the bit never collapses
    wire [4:0] ph2_len = resync_edge_early ?
        ((seg_len(ph2_field) > jump_len) ? seg_len(ph2_field) - jump_len : 5'h01)
        : seg_len(ph2_field);

    always @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            presc_cnt     <= 6'h00;
            tq_cnt        <= 5'h00;
            seg           <= SEG_SYNC;
            rx_hist       <= 3'h7;
            bit_value     <= 1'b1;
            sample_strobe <= 1'b0;
        end else begin
            sample_strobe <= 1'b0;
            if (!timing_valid || !controller_enable) begin
                presc_cnt <= 6'h00;
                tq_cnt    <= 5'h00;
                seg       <= SEG_SYNC;
            end else begin
                presc_cnt <= tq_tick ? 6'h00 : presc_cnt + 6'h01;
                if (tq_tick) begin
                    rx_hist <= {rx_hist[1:0], rx_sync};
                    case (seg)
                        SEG_SYNC: begin
                            seg    <= SEG_PROP;
                            tq_cnt <= 5'h00;
                        end
                        SEG_PROP: begin
                            if (tq_cnt + 5'h01 >= seg_len(prop_field)) begin
                                seg    <= SEG_PH1;
                                tq_cnt <= 5'h00;
                            end else begin
                                tq_cnt <= tq_cnt + 5'h01;
                            end
                        end
                        SEG_PH1: begin
                            if (tq_cnt + 5'h01 >= ph1_len) begin
                                seg           <= SEG_PH2;
                                tq_cnt        <= 5'h00;
                                sample_strobe <= 1'b1;
                                bit_value     <= triple_sample_sel ?
                                    ((rx_hist[1] & rx_hist[0]) | (rx_hist[1] & rx_sync) |
                                     (rx_hist[0] & rx_sync)) : rx_sync;
                            end else begin
                                tq_cnt <= tq_cnt + 5'h01;
                            end
                        end
                        SEG_PH2: begin
                            if (tq_cnt + 5'h01 >= ph2_len) begin
                                seg    <= SEG_SYNC;
                                tq_cnt <= 5'h00;
                            end else begin
                                tq_cnt <= tq_cnt + 5'h01;
                            end
                        end
                        default: seg <= SEG_SYNC;
                    endcase
                end
            end
        end
    end
endmodule // cbtcp_top

// File: cbtcp_consts.vh
// Purpose: constants for the can bit timing / channel page block
// Assumes: sfr addresses are 8 bits wide
// Notes:   prescaler field counts can system clock periods minus one; segment fields count quanta minus one
`ifndef CBTCP_CONSTS_VH
`define CBTCP_CONSTS_VH
`define CBTCP_ADDR_PAGE      8'hb1
`define CBTCP_ADDR_CHCTRL    8'hb3
`define CBTCP_ADDR_BT1       8'hb4
`define CBTCP_ADDR_BT2       8'hb5
`define CBTCP_ADDR_BT3       8'hb6
`define CBTCP_PAGE_RESET     8'h00
`define CBTCP_CHAN_LAST      4'he
`define CBTCP_CFG_DISABLED   2'h0
`define CBTCP_CFG_TX         2'h1
`define CBTCP_CFG_RX         2'h2
`define CBTCP_CFG_RXBUF      2'h3
`define CBTCP_PAGE_CHAN      7:4
`define CBTCP_PAGE_STEP_N    3
`define CBTCP_PAGE_INDEX     2:0
`define CBTCP_CHCTRL_CFG     7:6
`define CBTCP_BT1_PRESC      6:1
`define CBTCP_BT2_JUMP       6:5
`define CBTCP_BT2_PROP       3:1
`define CBTCP_BT3_PH2        6:4
`define CBTCP_BT3_PH1        3:1
`define CBTCP_BT3_TRIPLE     0
`endif

// File: cbtcp_chan_mem.v
// Purpose: per-channel control byte store, fifteen entries
// Assumes: one write port, one read port, registered read data
// Notes:   contents undefined after reset, as the register is
`timescale 1ns/1ps
`include "cbtcp_consts.vh"
module cbtcp_chan_mem (
    // clock
    input  wire       clk_sys,
    // write side
    input  wire       wr_en,
    input  wire [3:0] wr_addr,
    input  wire [7:0] wr_data,
    // read side
    input  wire [3:0] rd_addr,
    output reg  [7:0] rd_data
);
    reg [7:0] mem [0:14];

    always @(posedge clk_sys) begin
        if (wr_en && wr_addr <= `CBTCP_CHAN_LAST) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_addr <= `CBTCP_CHAN_LAST) begin
            rd_data <= mem[rd_addr];
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule // cbtcp_chan_mem

// File: cbtcp_top_sva.sv
// Purpose: port checker for cbtcp_top
// Assumes: one clock, rst_n low resets
// Notes:   index auto-step mode is mirrored from page writes
`timescale 1ns/1ps
module cbtcp_chk (
    // clock and reset
    input wire        clk_sys,
    input wire        rst_n,
    // sfr port
    input wire [7:0]  sfr_addr,
    input wire [7:0]  sfr_wdata,
    input wire        sfr_wr,
    input wire        sfr_rd,
    input wire [7:0]  sfr_rdata,
    // status and strobes
    input wire        data_access,
    input wire        controller_enable,
    input wire        sample_strobe,
    input wire [14:0] channel_enabled,
    input wire [3:0]  channel_select,
    input wire [2:0]  byte_index
);
    logic pg_wr;
    logic step_off;
    assign pg_wr = sfr_wr && sfr_addr == 8'hb1;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) step_off <= 1'b0;
        else if (pg_wr) step_off <= sfr_wdata[3];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // two low edges let the internal reset copy settle before the first look
    a_page_rst_zero: assert property (disable iff (1'b0) !rst_n [*2] |->
        channel_select == 4'h0 && byte_index == 3'h0) else $error("page fields not cleared in reset");
    a_page_write_fields: assert property (pg_wr && !data_access |=>
        channel_select == $past(sfr_wdata[7:4]) && byte_index == $past(sfr_wdata[2:0])) else $error("page write lost");
    a_index_step_up: assert property (data_access && !pg_wr && !step_off |=>
        byte_index == $past(byte_index) + 3'h1) else $error("byte index did not step");
    a_index_hold_still: assert property (data_access && !pg_wr && step_off |=> $stable(byte_index))
        else $error("byte index moved with auto-step off");
    a_page_read_back: assert property (sfr_rd && sfr_addr == 8'hb1 |=>
        sfr_rdata == {$past(channel_select), $past(step_off), $past(byte_index)}) else $error("page read wrong");
    a_disabled_no_strobe: assert property (!controller_enable [*3] |-> !sample_strobe)
        else $error("sample strobe while disabled");
    a_strobe_single_pulse: assert property (sample_strobe |=> !sample_strobe)
        else $error("sample strobe longer than one cycle");
    a_chan_rst_zero: assert property (disable iff (1'b0) !rst_n [*2] |-> channel_enabled == 15'h0)
        else $error("channel enables not cleared in reset");
    a_chctrl_sets_enable: assert property (sfr_wr && sfr_addr == 8'hb3 && channel_select != 4'hf |=>
        channel_enabled[$past(channel_select)] == ($past(sfr_wdata[7:6]) != 2'h0)) else $error("enable bit wrong");
    c_page_write: cover property (pg_wr);
    c_index_step: cover property (data_access && !step_off);
    c_sample: cover property (sample_strobe);
endmodule // cbtcp_chk
bind cbtcp_top cbtcp_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .data_access(data_access),
    .controller_enable(controller_enable), .sample_strobe(sample_strobe), .channel_enabled(channel_enabled),
    .channel_select(channel_select), .byte_index(byte_index));

// File: cbtcp_can_node.sv
// Purpose: far node on the can bus, drives one level for a span
// Assumes: bench pulses send for one cycle
// Notes:   released bus goes recessive through termination
`timescale 1ns/1ps
module cbtcp_can_node (
    // clock and control
    input  wire        clk_sys,
    input  wire        send,
    input  wire [15:0] level_clks,
    input  wire        level,
    // bus
    output wire        can_rx
);
    logic [15:0] left = 16'h0;
    always @(posedge clk_sys) begin
        if (send) left <= level_clks;
        else if (left != 16'h0) left <= left - 16'h1;
    end
    assign can_rx = (left != 16'h0) ? level : 1'b1;
endmodule // cbtcp_can_node

// File: testbench.sv
// Purpose: self-checking bench for cbtcp_top
// Assumes: resync edge levels held over whole bits while a bit time is measured
// Notes:   read data sampled two edges after the read
`timescale 1ns/1ps
module testbench;
    logic        clk_sys, rst_n, sfr_wr, sfr_rd, data_access, controller_enable, send, can_rx, bit_value, sample_strobe;
    logic        resync_early, resync_late;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;
    logic [14:0] channel_enabled;
    logic [3:0]  channel_select;
    logic [2:0]  byte_index;
    int          failures = 0, checked = 0, gap, n;
    cbtcp_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .data_access(data_access), .controller_enable(controller_enable),
        .can_rx(can_rx), .bit_value(bit_value), .sample_strobe(sample_strobe), .resync_edge_early(resync_early),
        .resync_edge_late(resync_late), .channel_enabled(channel_enabled), .channel_select(channel_select),
        .byte_index(byte_index));
    cbtcp_can_node node (.clk_sys(clk_sys), .send(send), .level_clks(16'd400), .level(1'b0), .can_rx(can_rx));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task summarize;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task check(input logic [14:0] seen, input logic [14:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        tick(2);
        rv = sfr_rdata;
    endtask
    task step;
        @(posedge clk_sys) data_access <= 1'b1;
        @(posedge clk_sys) data_access <= 1'b0;
        tick(1);
    endtask
    // wait for a strobe, then count to the next one
    task strobe_gap;
        gap = 0;
        while (sample_strobe !== 1'b1 && gap < 300) begin
            tick(1);
            gap++;
        end
        gap = 0;
        do begin
            tick(1);
            gap++;
        end while (sample_strobe !== 1'b1 && gap < 300);
    endtask
    task t_page;
        rd(8'hb1);
        check(rv, 15'h0, "page after reset");
        wr(8'hb1, 8'h35);
        tick(1);
        check(channel_select, 15'h3, "channel");
        check(byte_index, 15'h5, "index");
        for (n = 6; n < 9; n++) begin
            step;
            check(byte_index, 15'(n % 8), "stepped index");
        end
        rd(8'hb1);
        check(rv, 15'h30, "page read");
        wr(8'hb1, 8'hed);
        step;
        check(byte_index, 15'h5, "held index");
        check(channel_select, 15'he, "last channel");
    endtask
    task t_chctrl;
        wr(8'hb1, 8'h28);
        for (n = 0; n < 4; n++) begin
            wr(8'hb3, {n[1:0], 6'h25});
            tick(1);
            check(channel_enabled[2], 15'(n != 0), "channel enable");
            rd(8'hb3);
            check(rv, {n[1:0], 6'h25}, "control read");
        end
    endtask
    task t_timing(input logic [5:0] presc, input logic [2:0] ph2, input logic [2:0] ph1, input logic triple);
        tick(400); // far node must have released the bus, else the idle check sees a dominant bit and fails
        @(posedge clk_sys) controller_enable <= 1'b0;
        wr(8'hb4, {1'b0, presc, 1'b0});
        wr(8'hb5, 8'h22); // jump field 1, propagation field 1
        wr(8'hb6, {1'b0, ph2, ph1, triple});
        rd(8'hb6);
        check(rv[6:0], {ph2, ph1, triple}, "phase reg");
        @(posedge clk_sys) controller_enable <= 1'b1;
        strobe_gap;
        check(gap, 15'((presc + 1) * (ph1 + ph2 + 5)), "bit time");
        check(bit_value, 15'h1, "idle bit");
        @(posedge clk_sys) resync_late <= 1'b1;
        strobe_gap; // first gap straddles the change, so only the second counts
        strobe_gap;
        check(gap, 15'((presc + 1) * (ph1 + ph2 + 7)), "late bit time");
        @(posedge clk_sys) resync_late <= 1'b0;
        resync_early <= 1'b1;
        strobe_gap;
        strobe_gap;
        n = (ph2 > 3'h1) ? ph2 - 1 : 1; // two-quantum jump, phase two never below one quantum
        check(gap, 15'((presc + 1) * (ph1 + n + 4)), "early bit time");
        @(posedge clk_sys) resync_early <= 1'b0;
        wr(8'hb6, 8'h00);
        @(posedge clk_sys) send <= 1'b1;
        @(posedge clk_sys) send <= 1'b0;
        strobe_gap;
        strobe_gap;
        check(bit_value, 15'h0, "sampled bit");
        @(posedge clk_sys) controller_enable <= 1'b0;
        rd(8'hb6);
        check(rv[6:0], {ph2, ph1, triple}, "locked phase reg");
    endtask
    initial begin
        {rst_n, sfr_wr, sfr_rd, data_access, controller_enable, send, resync_early, resync_late} = 8'h0;
        sfr_addr = 8'h0;
        sfr_wdata = 8'h0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        tick(4);
        t_page;
        t_chctrl;
        t_timing(6'h00, 3'h1, 3'h2, 1'b0);
        t_timing(6'h01, 3'h3, 3'h1, 1'b1);
        summarize;
    end
    initial begin
        #200000;
        failures++;
        summarize;
    end
endmodule // testbench
